// >>> bench/ddl_dac_model.sv
`timescale 1ns/10ps
`default_nettype none
// Level-sensitive model of the dual converter's input and output latches.
module ddl_dac_model (
	// Bus from the host.
	input wire       chipSel_n,
	input wire       writeStrobe_n,
	input wire       section_addr_bit0,
	input wire       section_addr_bit1,
	input wire [7:0] dataBus,
	input wire       output_load_strobe_n,
	// Codes that set the two outputs.
	output reg [11:0] dacA,
	output reg [11:0] dacB
);
	reg [7:0] aLo, bLo;
	reg [3:0] aHi, bHi;
	// Selected section is transparent and keeps its last byte once deselected.
	always @* begin
		if (!chipSel_n && !writeStrobe_n) begin
			case ({section_addr_bit1, section_addr_bit0})
			2'h0: aLo = dataBus;
			2'h1: aHi = dataBus[3:0];
			2'h2: bLo = dataBus;
			default: bHi = dataBus[3:0];
			endcase
		end
	end
	// Output latches follow while the strobe is low; outputs are the raw codes.
	always @* begin
		if (!output_load_strobe_n) begin
			dacA = {aHi, aLo};
			dacB = {bHi, bLo};
		end
	end
endmodule // ddl_dac_model
`default_nettype wire

// >>> bench/ddl_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the host pins for the discipline the converter expects of them.
module ddl_host_chk (
	// Clock and reset.
	input wire       clk_sys,
	input wire       rst,
	// Device pins and completion.
	input wire       doneP,
	input wire       writeStrobe_n,
	input wire       chipSel_n,
	input wire       section_addr_bit0,
	input wire       section_addr_bit1,
	input wire [7:0] dataBus,
	input wire       output_load_strobe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Ten cycles of low load strobe, split so each repetition stays small.
	sequence s_loadHeld;
		(!output_load_strobe_n) [*8] ##1 (!output_load_strobe_n) [*2];
	endsequence
	property p_loadWidth;
		$fell(output_load_strobe_n) |-> s_loadHeld;
	endproperty
	a_loadWidth: assert property (p_loadWidth) else $error("load pulse short");
	property p_noOverlap;
		!output_load_strobe_n |-> chipSel_n && writeStrobe_n;
	endproperty
	a_noOverlap: assert property (p_noOverlap) else $error("load overlaps write");
	property p_nibble;
		!writeStrobe_n && section_addr_bit0 |-> dataBus[7:4] == 4'h0;
	endproperty
	a_nibble: assert property (p_nibble) else $error("upper byte not right-justified");
	property p_steady;
		!writeStrobe_n && !$past(writeStrobe_n)
			|-> $stable({section_addr_bit1, section_addr_bit0, dataBus});
	endproperty
	a_steady: assert property (p_steady) else $error("bus moved during write");
	property p_doneAfterLoad;
		$rose(output_load_strobe_n) |-> ##[1:8] doneP;
	endproperty
	a_doneAfterLoad: assert property (p_doneAfterLoad) else $error("no done after load");
endmodule // ddl_host_chk
bind ddl_host_ctrl ddl_host_chk chk_u (.clk_sys(clk_sys), .rst(rst), .doneP(doneP),
	.writeStrobe_n(writeStrobe_n), .chipSel_n(chipSel_n),
	.section_addr_bit0(section_addr_bit0), .section_addr_bit1(section_addr_bit1),
	.dataBus(dataBus), .output_load_strobe_n(output_load_strobe_n));
`default_nettype wire

// >>> bench/test_ddl_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_ddl_host_ctrl;
	reg         clk_sys, rst, reqValid, writeA, writeB, loadAfter, loadOnly;
	reg         clkEn = 1'b1;
	reg  [11:0] codeA, codeB;
	reg  [51:0] rows [0:3];
	integer     errors, comparisons, i, n;
	wire        reqReady, busy, doneP, csN, wrN, adr0, adr1, ldN;
	wire [7:0]  dataBus;
	wire [11:0] dacA, dacB;
	ddl_host_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .reqValid(reqValid),
		.reqReady(reqReady), .codeA(codeA), .codeB(codeB), .writeA(writeA), .writeB(writeB),
		.loadAfter(loadAfter), .loadOnly(loadOnly), .busy(busy), .doneP(doneP),
		.chipSel_n(csN), .writeStrobe_n(wrN), .section_addr_bit0(adr0),
		.section_addr_bit1(adr1), .dataBus(dataBus), .output_load_strobe_n(ldN));
	ddl_dac_model dev_u (.chipSel_n(csN), .writeStrobe_n(wrN), .section_addr_bit0(adr0),
		.section_addr_bit1(adr1), .dataBus(dataBus), .output_load_strobe_n(ldN),
		.dacA(dacA), .dacB(dacB));
	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task chk(input [63:0] name, input [11:0] exp, input [11:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("MISMATCH %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// Waits for idle first, so a request is never offered while refused.
	task run_req(input [27:0] req);
		begin
			n = 0;
			while (reqReady !== 1'b1) @(negedge clk_sys);
			{codeA, codeB, writeA, writeB, loadAfter, loadOnly} = req;
			reqValid = 1'b1;
			@(negedge clk_sys);
			reqValid = 1'b0;
			while (doneP !== 1'b1 && n < 2000) begin
				@(negedge clk_sys);
				n = n + 1;
			end
			if (n == 2000) errors = errors + 1;
		end
	endtask
	task final_report;
		begin
			if (errors == 0 && comparisons > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// A hang ends the run as a failure.
	initial begin
		#50000;
		errors = errors + 1;
		final_report;
	end
	// Rows: request fields, then expected output codes of both channels.
	initial begin
		errors = 0;
		comparisons = 0;
		rst = 1'b1;
		reqValid = 1'b0;
		{codeA, codeB, writeA, writeB, loadAfter, loadOnly} = 28'h0;
		rows[0] = {12'h123, 12'habc, 4'he, 12'h123, 12'habc};
		rows[1] = {12'hfff, 12'h800, 4'h8, 12'h123, 12'habc};
		rows[2] = {12'h000, 12'h000, 4'h1, 12'hfff, 12'habc};
		rows[3] = {12'h5a5, 12'h7ff, 4'h6, 12'hfff, 12'h7ff};
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		chk("ldN", 12'h1, {11'h0, ldN});
		chk("data", 12'h0, {4'h0, dataBus});
		for (i = 0; i < 4; i = i + 1) begin
			run_req(rows[i][51:24]);
			chk("dacA", rows[i][23:12], dacA);
			chk("dacB", rows[i][11:0], dacB);
		end
		// Reset lands in mid-write; the bus must let go and a fresh request must work.
		{codeA, writeA, writeB, loadAfter, loadOnly} = {12'h3c3, 4'he};
		reqValid = 1'b1;
		@(negedge clk_sys);
		reqValid = 1'b0;
		repeat (30) @(negedge clk_sys);
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		chk("csN", 12'h1, {11'h0, csN});
		chk("busy", 12'h0, {11'h0, busy});
		chk("rdy", 12'h1, {11'h0, reqReady});
		run_req({12'h3c3, 12'h000, 4'he});
		chk("dacA", 12'h3c3, dacA);
		chk("dacB", 12'h000, dacB);
		// A low enable must stretch the load pulse well past its normal length.
		{codeA, codeB, writeA, writeB, loadAfter, loadOnly} = {24'h0, 4'h1};
		reqValid = 1'b1;
		@(negedge clk_sys);
		reqValid = 1'b0;
		clkEn = 1'b0;
		repeat (20) @(negedge clk_sys);
		chk("ldFrz", 12'h0, {11'h0, ldN});
		chk("busy", 12'h1, {11'h0, busy});
		clkEn = 1'b1;
		repeat (20) @(negedge clk_sys);
		chk("ldN", 12'h1, {11'h0, ldN});
		chk("rdy", 12'h1, {11'h0, reqReady});
		chk("dacA", 12'h3c3, dacA);
		final_report;
	end
endmodule // test_ddl_host_ctrl
`default_nettype wire

// >>> logic/ddl_defs.vh
`ifndef DDL_DEFS_VH
`define DDL_DEFS_VH

// Section select codes on the two address lines.
`define DDL_SEC_A_LO   2'h0
`define DDL_SEC_A_HI   2'h1
`define DDL_SEC_B_LO   2'h2
`define DDL_SEC_B_HI   2'h3

// Bit layout of a 12-bit code.
`define DDL_LO_MSB     7
`define DDL_HI_LSB     8
`define DDL_HI_MSB     11
`define DDL_HI_W       4

// Timing in ns and the clock period in ns.
`define DDL_CLK_NS          5
`define DDL_SETUP_NS        30
`define DDL_WRITE_NS        50
`define DDL_HOLD_NS         10
`define DDL_MIN_LOAD_NS     50

// Idle value of the byte bus.
`define DDL_BUS_IDLE   8'h00

`endif

// >>> logic/ddl_host_ctrl.v
// Function
// - Byte data right-justified; upper nibble on low lines.
// - Load stays low minimum width after write ends.
// - Host maps four sections plus one load address; this controller drives the load strobe as its own pin.
// - Load address write pulses the load strobe; here the state machine pulses it directly, with no load address.
`timescale 1ns/10ps
`default_nettype none
`include "ddl_defs.vh"

// Host-side controller that writes the codes picked by writeA and writeB into the dual converter
// as two byte writes per code, then pulses the shared load strobe if loadAfter or loadOnly is set.
module ddl_host_ctrl #(
	parameter SETUP_NS    = `DDL_SETUP_NS,
	parameter WRITE_NS    = `DDL_WRITE_NS,
	parameter HOLD_NS     = `DDL_HOLD_NS,
	parameter MIN_LOAD_NS = `DDL_MIN_LOAD_NS
) (
	// Clock, reset and enable.
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        clkEn,
	// Request side.
	input  wire        reqValid,
	output wire        reqReady,
	input  wire [11:0] codeA,
	input  wire [11:0] codeB,
	input  wire        writeA,
	input  wire        writeB,
	input  wire        loadAfter,
	input  wire        loadOnly,
	output wire        busy,
	output reg         doneP,
	// Device pins.
	output reg         chipSel_n,
	output reg         writeStrobe_n,
	output reg         section_addr_bit0,
	output reg         section_addr_bit1,
	output reg  [7:0]  dataBus,
	output reg         output_load_strobe_n
);

	// Cycle counts; least times round up and never fall below one cycle.
	function [7:0] nsToCycles;
		input integer ns;
		integer c;
		begin
			c = (ns + `DDL_CLK_NS - 1) / `DDL_CLK_NS;
			if (c < 1) begin
				c = 1;
			end
			nsToCycles = c[7:0];
		end
	endfunction

	localparam [7:0] SETUP_CYC = nsToCycles(SETUP_NS);
	localparam [7:0] WRITE_CYC = nsToCycles(WRITE_NS);
	localparam [7:0] HOLD_CYC  = nsToCycles(HOLD_NS);
	localparam [7:0] LOAD_CYC  = nsToCycles(MIN_LOAD_NS);

	// One-hot states.
	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_SETUP = 6'h02;
	localparam [5:0] ST_WRITE = 6'h04;
	localparam [5:0] ST_HOLD  = 6'h08;
	localparam [5:0] ST_LOAD  = 6'h10;
	localparam [5:0] ST_GAP   = 6'h20;

	reg  [5:0]  state;
	reg  [5:0]  next_state;
	reg  [3:0]  pending;
	reg  [1:0]  curSec;
	reg  [11:0] latchA;
	reg  [11:0] latchB;
	reg         doLoad;
	reg         tmrLoad;
	reg  [7:0]  tmrCount;
	wire        tmrDone;
	wire [3:0]  wantSec;
	wire [1:0]  nextSec;

	// Byte for a section: low byte whole, upper nibble right-justified.
	function [7:0] sectionByte;
		input [1:0]  sec;
		input [11:0] a;
		input [11:0] b;
		begin
			case (sec)
				`DDL_SEC_A_LO: sectionByte = a[`DDL_LO_MSB:0];
				`DDL_SEC_A_HI: sectionByte = {4'h0, a[`DDL_HI_MSB:`DDL_HI_LSB]};
				`DDL_SEC_B_LO: sectionByte = b[`DDL_LO_MSB:0];
				default:       sectionByte = {4'h0, b[`DDL_HI_MSB:`DDL_HI_LSB]};
			endcase
		end
	endfunction

	// Lowest pending section first; the device takes any order.
	function [1:0] firstPending;
		input [3:0] p;
		begin
			if (p[0]) begin
				firstPending = `DDL_SEC_A_LO;
			end else if (p[1]) begin
				firstPending = `DDL_SEC_A_HI;
			end else if (p[2]) begin
				firstPending = `DDL_SEC_B_LO;
			end else begin
				firstPending = `DDL_SEC_B_HI;
			end
		end
	endfunction

	ddl_strobe_timer #(
		.W(8)
	) uTimer (
		.clk_sys(clk_sys),
		.rst    (rst),
		.clkEn  (clkEn),
		.load   (tmrLoad),
		.count  (tmrCount),
		.done   (tmrDone)
	);

	assign reqReady = state[0];
	assign busy     = ~state[0];

	// Section to drive next: from the fresh request when idle, else what is left.
	assign wantSec = state[0] ? {{2{writeB}}, {2{writeA}}} : pending;
	assign nextSec = firstPending(wantSec);

	// Next state and timer reload.
	always @* begin
		next_state = state;
		tmrLoad    = 1'b0;
		tmrCount   = SETUP_CYC;
		case (state)
			ST_IDLE: begin
				if (reqValid) begin
					if (loadOnly || (!writeA && !writeB)) begin
						next_state = loadOnly || loadAfter ? ST_LOAD : ST_GAP;
						tmrCount   = LOAD_CYC;
					end else begin
						next_state = ST_SETUP;
						tmrCount   = SETUP_CYC;
					end
					tmrLoad = 1'b1;
				end
			end
			ST_SETUP: begin
				if (tmrDone) begin
					next_state = ST_WRITE;
					tmrLoad    = 1'b1;
					tmrCount   = WRITE_CYC;
				end
			end
			ST_WRITE: begin
				if (tmrDone) begin
					next_state = ST_HOLD;
					tmrLoad    = 1'b1;
					tmrCount   = HOLD_CYC;
				end
			end
			ST_HOLD: begin
				if (tmrDone) begin
					tmrLoad = 1'b1;
					if (pending != 4'h0) begin
						next_state = ST_SETUP;
						tmrCount   = SETUP_CYC;
					end else if (doLoad) begin
						next_state = ST_LOAD;
						tmrCount   = LOAD_CYC;
					end else begin
						next_state = ST_GAP;
						tmrCount   = HOLD_CYC;
					end
				end
			end
			ST_LOAD: begin
				if (tmrDone) begin
					next_state = ST_GAP;
					tmrLoad    = 1'b1;
					tmrCount   = HOLD_CYC;
				end
			end
			ST_GAP: begin
				if (tmrDone) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Request capture, section bookkeeping and pin drive; all pins registered.
	always @(posedge clk_sys) begin
		if (rst) begin
			state                <= ST_IDLE;
			pending              <= 4'h0;
			curSec               <= `DDL_SEC_A_LO;
			latchA               <= 12'h000;
			latchB               <= 12'h000;
			doLoad               <= 1'b0;
			doneP                <= 1'b0;
			chipSel_n            <= 1'b1;
			writeStrobe_n        <= 1'b1;
			section_addr_bit0    <= 1'b0;
			section_addr_bit1    <= 1'b0;
			dataBus              <= `DDL_BUS_IDLE;
			output_load_strobe_n <= 1'b1;
		end else if (clkEn) begin
			state <= next_state;
			doneP <= 1'b0;
			if (state[0] && reqValid) begin
				latchA  <= codeA;
				latchB  <= codeB;
				pending <= loadOnly ? 4'h0 : {{2{writeB}}, {2{writeA}}};
				doLoad  <= loadOnly | loadAfter;
			end
			// Address and data settle before select and write fall.
			if (next_state == ST_SETUP && state != ST_SETUP) begin
				curSec            <= nextSec;
				section_addr_bit0 <= nextSec[0];
				section_addr_bit1 <= nextSec[1];
				dataBus           <= sectionByte(nextSec, state[0] ? codeA : latchA,
				                                 state[0] ? codeB : latchB);
			end
			// Select and write low together, load strobe kept high meanwhile.
			chipSel_n     <= ~(next_state == ST_WRITE);
			writeStrobe_n <= ~(next_state == ST_WRITE);
			// Rising select and write closes the section; data held one phase more.
			if (state == ST_WRITE && next_state == ST_HOLD) begin
				pending[curSec] <= 1'b0;
			end
			// Load pulse only after the write has ended, for the full width.
			output_load_strobe_n <= ~(next_state == ST_LOAD);
			if (state == ST_GAP && next_state == ST_IDLE) begin
				doneP   <= 1'b1;
				dataBus <= `DDL_BUS_IDLE;
			end
		end
	end

endmodule // ddl_host_ctrl

`default_nettype wire

// >>> logic/ddl_strobe_timer.v
`timescale 1ns/10ps
`default_nettype none

// Down counter that reports when a programmed phase length has run out.
module ddl_strobe_timer #(
	parameter W = 8
) (
	// Clock, reset and enable.
	input  wire         clk_sys,
	input  wire         rst,
	input  wire         clkEn,
	// Control.
	input  wire         load,
	input  wire [W-1:0] count,
	// Status.
	output wire         done
);

	reg [W-1:0] remain;

	// A load restarts the phase; otherwise the count runs down to zero and stops.
	always @(posedge clk_sys) begin
		if (rst) begin
			remain <= {W{1'b0}};
		end else if (clkEn) begin
			if (load) begin
				remain <= count;
			end else if (remain != {W{1'b0}}) begin
				remain <= remain - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Done looks at the count alone; gating it with load would close a loop
	// through the caller's reload decision, which is itself built from done.
	assign done = (remain == {W{1'b0}});

endmodule // ddl_strobe_timer

`default_nettype wire
